// ---- bcs_regs.sv ----
// Capability status register bank: split delay flag, clock code, bus/device/function
`timescale 1ns/100ps
module bcs_regs #(
    parameter logic [2:0] FUNC_NUM = 3'h0
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic reverse_mode_pin,
    input wire logic [2:0] sec_clk_code_pin,
    input wire logic split_delay_evt,
    input wire logic [7:0] pri_bus_num,
    input wire logic pri_pcix_mode,
    input wire logic sec_pcix_mode,
    input wire logic cfg_valid,
    input wire logic [3:0] cfg_cmd,
    input wire logic cfg_idsel,
    input wire logic [31:0] cfg_addr,
    input wire logic [31:0] cfg_wdata,
    input wire logic [3:0] cfg_byte_en,
    output logic [31:0] cfg_rdata,
    output logic cfg_rvalid,
    output logic [15:0] completer_id,
    output logic mixed_mode_id_use
);
    logic rev_meta_ff;
    logic rev_ff;
    logic [2:0] clk_meta_ff;
    logic [2:0] clk_sync_ff;
    logic split_dly_ff;
    logic [2:0] clk_code_ff;
    logic [4:0] dev_num_ff;
    logic [7:0] bus_num_ff;
    logic [31:0] rdata_ff;
    logic rvalid_ff;
    logic own_access;
    logic own_write;
    logic own_read;
    logic [7:0] reg_ofs;
    logic split_clr;
    logic [31:0] sec_status;
    logic [31:0] bridge_id;
    logic [31:0] nxt_rdata;

    // Strap and clock code arrive from pins, so they pass two flops first
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rev_meta_ff <= 1'b0;
            rev_ff <= 1'b0;
            clk_meta_ff <= 3'h0;
            clk_sync_ff <= 3'h0;
        end else begin
            rev_meta_ff <= reverse_mode_pin;
            rev_ff <= rev_meta_ff;
            clk_meta_ff <= sec_clk_code_pin;
            clk_sync_ff <= clk_meta_ff;
        end
    end

    // Decode of an address phase that targets this function
    assign reg_ofs = {cfg_addr[7:2], 2'h0};
    assign own_access = cfg_valid && cfg_idsel
        && (cfg_addr[1:0] == bcs_pkg::AD_TYPE0)
        && (cfg_addr[bcs_pkg::AD_FUNC_MSB:bcs_pkg::AD_FUNC_LSB] == FUNC_NUM);
    assign own_write = own_access && (cfg_cmd == bcs_pkg::CMD_CFG_WRITE);
    assign own_read = own_access && (cfg_cmd == bcs_pkg::CMD_CFG_READ);

    // clear only in reverse mode, byte lane 2 enabled
    assign split_clr = own_write && rev_ff && (reg_ofs == bcs_pkg::OFS_SEC_STATUS)
        && cfg_byte_en[2] && cfg_wdata[bcs_pkg::SPLIT_DLY_BIT];

    // sticky delay flag; a new event wins over a same-cycle clear
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            split_dly_ff <= bcs_pkg::SPLIT_DLY_RST;
        end else if (split_delay_evt) begin
            split_dly_ff <= 1'b1;
        end else if (split_clr) begin
            split_dly_ff <= 1'b0;
        end
    end

    // forced to zero in reverse mode so software never sees a stale code
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            clk_code_ff <= bcs_pkg::CLK_CODE_RST;
        end else if (rev_ff) begin
            clk_code_ff <= bcs_pkg::CLK_CODE_CONV;
        end else begin
            clk_code_ff <= clk_sync_ff;
        end
    end

    // device number captured on every own write, whatever the register
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            dev_num_ff <= bcs_pkg::DEV_RST;
        end else if (own_write) begin
            dev_num_ff <= cfg_addr[bcs_pkg::AD_DEV_MSB:bcs_pkg::AD_DEV_LSB];
        end
    end

    // alternate copy of the primary bus number, one cycle behind it
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            bus_num_ff <= bcs_pkg::BUS_RST;
        end else begin
            bus_num_ff <= pri_bus_num;
        end
    end

    // Register images; unlisted low bits of 0x80 belong to other logic and read zero
    always_comb begin
        sec_status = 32'h0;
        sec_status[bcs_pkg::SPLIT_DLY_BIT] = split_dly_ff;
        sec_status[bcs_pkg::CLK_CODE_MSB:bcs_pkg::CLK_CODE_LSB] = clk_code_ff;
        sec_status[31:25] = 7'h0;
        bridge_id = 32'h0;
        bridge_id[bcs_pkg::FUNC_MSB:bcs_pkg::FUNC_LSB] = FUNC_NUM;
        bridge_id[bcs_pkg::DEV_MSB:bcs_pkg::DEV_LSB] = dev_num_ff;
        bridge_id[bcs_pkg::BUS_MSB:bcs_pkg::BUS_LSB] = bus_num_ff;
    end

    // Read mux; unmapped offsets answer zero
    always_comb begin
        case (reg_ofs)
            bcs_pkg::OFS_SEC_STATUS: nxt_rdata = sec_status;
            bcs_pkg::OFS_BRIDGE_ID: nxt_rdata = bridge_id;
            default: nxt_rdata = 32'h0;
        endcase
    end

    // Read data is registered, valid one cycle after the address phase
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rdata_ff <= 32'h0;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= own_read;
            if (own_read) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end
    assign cfg_rdata = rdata_ff;
    assign cfg_rvalid = rvalid_ff;

    // completer identifier from the live fields
    assign completer_id = {bus_num_ff, dev_num_ff, FUNC_NUM};
    // flag that the identifier is needed for a mixed-mode pair
    assign mixed_mode_id_use = pri_pcix_mode ^ sec_pcix_mode;

    // Checks
    property p_split_set;
        @(posedge core_clk) disable iff (reset)
        split_delay_evt |=> split_dly_ff;
    endproperty
    a_split_set: assert property (p_split_set) else $error("delay flag not set");

    property p_split_fwd_ro;
        @(posedge core_clk) disable iff (reset)
        (!rev_ff && split_dly_ff) |=> split_dly_ff;
    endproperty
    a_split_fwd_ro: assert property (p_split_fwd_ro) else $error("flag cleared in fwd");

    property p_split_clear;
        @(posedge core_clk) disable iff (reset)
        (split_clr && !split_delay_evt) |=> !split_dly_ff;
    endproperty
    a_split_clear: assert property (p_split_clear) else $error("flag not cleared");

    property p_clk_follow;
        @(posedge core_clk) disable iff (reset)
        !rev_ff |=> (clk_code_ff == $past(clk_sync_ff));
    endproperty
    a_clk_follow: assert property (p_clk_follow) else $error("clock code stale");

    property p_clk_rev_zero;
        @(posedge core_clk) disable iff (reset)
        rev_ff [*2] |-> (clk_code_ff == bcs_pkg::CLK_CODE_CONV);
    endproperty
    a_clk_rev_zero: assert property (p_clk_rev_zero) else $error("code nonzero in rev");

    property p_dev_load;
        @(posedge core_clk) disable iff (reset)
        own_write |=> (dev_num_ff == $past(cfg_addr[15:11]));
    endproperty
    a_dev_load: assert property (p_dev_load) else $error("device number not loaded");

    property p_dev_hold;
        @(posedge core_clk) disable iff (reset)
        !own_write |=> $stable(dev_num_ff);
    endproperty
    a_dev_hold: assert property (p_dev_hold) else $error("device number moved");

    property p_bus_mirror;
        @(posedge core_clk) disable iff (reset)
        1'b1 |=> (bus_num_ff == $past(pri_bus_num));
    endproperty
    a_bus_mirror: assert property (p_bus_mirror) else $error("bus number mismatch");

    property p_rd_reserved;
        @(posedge core_clk) disable iff (reset)
        (own_read && reg_ofs == bcs_pkg::OFS_SEC_STATUS) |=> (cfg_rdata[31:25] == 7'h0)
            && cfg_rvalid;
    endproperty
    a_rd_reserved: assert property (p_rd_reserved) else $error("reserved bits set");

    // Identifier must match what a read of the identity register returned
    property p_cpl_id;
        @(posedge core_clk) disable iff (reset)
        (own_read && reg_ofs == bcs_pkg::OFS_BRIDGE_ID)
            |=> (cfg_rdata[15:0] == $past(completer_id));
    endproperty
    a_cpl_id: assert property (p_cpl_id) else $error("completer id mismatch");

    property p_func_ro;
        @(posedge core_clk) disable iff (reset)
        cfg_rvalid && $past(reg_ofs) == bcs_pkg::OFS_BRIDGE_ID |-> cfg_rdata[2:0] == FUNC_NUM;
    endproperty
    a_func_ro: assert property (p_func_ro) else $error("function field wrong");

    c_set_clear: cover property (@(posedge core_clk) disable iff (reset)
        split_delay_evt ##[1:20] split_clr);
    c_dev_write: cover property (@(posedge core_clk) disable iff (reset) own_write);
    c_rev_read: cover property (@(posedge core_clk) disable iff (reset) own_read && rev_ff);
    c_mixed: cover property (@(posedge core_clk) disable iff (reset) mixed_mode_id_use);
endmodule

// ---- bcs_pkg.sv ----
// Constants shared by the bridge capability status register bank
package bcs_pkg;
    // Configuration commands on the bus
    localparam logic [3:0] CMD_CFG_READ = 4'hA;
    localparam logic [3:0] CMD_CFG_WRITE = 4'hB;
    // Register byte offsets
    localparam logic [7:0] OFS_SEC_STATUS = 8'h80;
    localparam logic [7:0] OFS_BRIDGE_ID = 8'h84;
    // Secondary status fields
    localparam int SPLIT_DLY_BIT = 21;
    localparam int CLK_CODE_LSB = 22;
    localparam int CLK_CODE_MSB = 24;
    localparam logic SPLIT_DLY_RST = 1'b0;
    localparam logic [2:0] CLK_CODE_RST = 3'h0;
    localparam logic [2:0] CLK_CODE_CONV = 3'h0;
    localparam logic [2:0] CLK_CODE_66 = 3'h1;
    localparam logic [2:0] CLK_CODE_133 = 3'h2;
    // Bridge identity fields
    localparam int FUNC_LSB = 0;
    localparam int FUNC_MSB = 2;
    localparam int DEV_LSB = 3;
    localparam int DEV_MSB = 7;
    localparam int BUS_LSB = 8;
    localparam int BUS_MSB = 15;
    localparam logic [2:0] FUNC_RST = 3'h0;
    localparam logic [4:0] DEV_RST = 5'h1F;
    localparam logic [7:0] BUS_RST = 8'hFF;
    // Address phase fields of a type-0 configuration access
    localparam int AD_DEV_LSB = 11;
    localparam int AD_DEV_MSB = 15;
    localparam int AD_FUNC_LSB = 8;
    localparam int AD_FUNC_MSB = 10;
    localparam logic [1:0] AD_TYPE0 = 2'h0;
endpackage

// ---- bcs_cfg_master.sv ----
// Configuration master model that issues accesses to the register bank with the address the caller gives
`timescale 1ns/100ps
module bcs_cfg_master (
    input wire logic core_clk,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_rvalid,
    output logic cfg_valid,
    output logic [3:0] cfg_cmd,
    output logic cfg_idsel,
    output logic [31:0] cfg_addr,
    output logic [31:0] cfg_wdata,
    output logic [3:0] cfg_byte_en
);
    // Idle bus state at time zero
    initial begin
        cfg_valid = 1'b0;
        cfg_cmd = 4'h0;
        cfg_idsel = 1'b0;
        cfg_addr = 32'h0;
        cfg_wdata = 32'h0;
        cfg_byte_en = 4'hF;
    end
    task automatic access(input logic [3:0] cmd, input logic sel, input logic [31:0] adr,
        input logic [31:0] wd, output logic [31:0] rd);
        @(negedge core_clk);
        cfg_valid = 1'b1;
        cfg_cmd = cmd;
        cfg_idsel = sel;
        cfg_addr = adr;
        cfg_wdata = wd;
        @(negedge core_clk);
        // Released lines flip so a stale phase never passes for a live one
        cfg_valid = 1'b0;
        cfg_idsel = 1'b0;
        cfg_addr = ~adr;
        cfg_wdata = ~wd;
        rd = cfg_rvalid ? cfg_rdata : 32'hBAD0BAD0;
    endtask
    // Byte lanes for the next writes, changed on a falling edge like the rest
    task automatic set_byte_en(input logic [3:0] be);
        @(negedge core_clk);
        cfg_byte_en = be;
    endtask
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the capability status register bank
`timescale 1ns/100ps
module tb_top;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic reverse_mode_pin = 1'b0;
    logic [2:0] sec_clk_code_pin = 3'h0;
    logic split_delay_evt = 1'b0;
    logic [7:0] pri_bus_num = 8'h3C;
    logic pri_pcix_mode = 1'b0;
    logic sec_pcix_mode = 1'b0;
    logic cfg_valid, cfg_idsel, cfg_rvalid, mixed_mode_id_use;
    logic [3:0] cfg_cmd, cfg_byte_en;
    logic [31:0] cfg_addr, cfg_wdata, cfg_rdata, rd;
    logic [15:0] completer_id;
    int failures = 0;
    int cmp_count = 0;
    typedef struct packed {logic [2:0] code; logic [31:0] exp;} bcs_row_t;
    bcs_row_t rows[3] = '{{3'h0, 32'h0}, {3'h1, 32'h00400000}, {3'h2, 32'h00800000}};

    bcs_regs uut (.core_clk(core_clk), .reset(reset), .reverse_mode_pin(reverse_mode_pin),
        .sec_clk_code_pin(sec_clk_code_pin), .split_delay_evt(split_delay_evt),
        .pri_bus_num(pri_bus_num), .pri_pcix_mode(pri_pcix_mode),
        .sec_pcix_mode(sec_pcix_mode), .cfg_valid(cfg_valid), .cfg_cmd(cfg_cmd),
        .cfg_idsel(cfg_idsel), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_byte_en(cfg_byte_en), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
        .completer_id(completer_id), .mixed_mode_id_use(mixed_mode_id_use));
    bcs_cfg_master cfg_master (.core_clk(core_clk), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid), .cfg_valid(cfg_valid), .cfg_cmd(cfg_cmd),
        .cfg_idsel(cfg_idsel), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_byte_en(cfg_byte_en));

    // 25 MHz bench clock
    always #20 core_clk = ~core_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic rd_reg(input logic [7:0] ofs);
        cfg_master.access(bcs_pkg::CMD_CFG_READ, 1'b1, {24'h0, ofs}, 32'h0, rd);
    endtask
    task automatic wr(input logic [31:0] adr, input logic [31:0] wd);
        cfg_master.access(bcs_pkg::CMD_CFG_WRITE, 1'b1, adr, wd, rd);
    endtask
    // One-cycle delay event, launched on a falling edge
    task automatic pulse_evt();
        @(negedge core_clk);
        split_delay_evt = 1'b1;
        @(negedge core_clk);
        split_delay_evt = 1'b0;
    endtask

    // Watchdog: the whole run needs under a hundred cycles
    initial begin
        repeat (2000) @(posedge core_clk);
        failures++;
        test_done();
    end

    // Main sequence
    initial begin
        repeat (5) @(negedge core_clk);
        check({16'h0, completer_id}, 32'h0000FFF8);
        reset = 1'b0;
        repeat (3) @(negedge core_clk);
        rd_reg(8'h84);
        check(rd, 32'h00003CF8);
        rd_reg(8'h80);
        check(rd, 32'h0);
        $display("reset values test done");
        // Clock codes pass through sync before reading
        foreach (rows[i]) begin
            sec_clk_code_pin = rows[i].code;
            repeat (4) @(negedge core_clk);
            rd_reg(8'h80);
            check(rd, rows[i].exp);
        end
        $display("clock code test done");
        wr(32'h00005884, 32'h0);
        rd_reg(8'h84);
        check(rd, 32'h00003C58);
        check({16'h0, completer_id}, 32'h00003C58);
        // Each access misses one condition, so no capture may happen
        cfg_master.access(bcs_pkg::CMD_CFG_READ, 1'b1, 32'h00001884, 32'h0, rd);
        cfg_master.access(bcs_pkg::CMD_CFG_WRITE, 1'b0, 32'h00001884, 32'h0, rd);
        wr(32'h00001885, 32'h0);
        wr(32'h00001984, 32'h0);
        check({16'h0, completer_id}, 32'h00003C58);
        // A refused read must bring no valid strobe back
        cfg_master.access(bcs_pkg::CMD_CFG_READ, 1'b0, 32'h00000084, 32'h0, rd);
        check(rd, 32'hBAD0BAD0);
        rd_reg(8'h88);
        check(rd, 32'h0);
        // Bus number field follows the primary bus number
        pri_bus_num = 8'h5A;
        rd_reg(8'h84);
        check(rd, 32'h00005A58);
        check({16'h0, completer_id}, 32'h00005A58);
        $display("device capture test done");
        @(negedge core_clk);
        split_delay_evt = 1'b1;
        @(negedge core_clk);
        split_delay_evt = 1'b0;
        rd_reg(8'h80);
        check(rd, 32'h00A00000);
        wr(32'h00000080, 32'hFFFFFFFF);
        rd_reg(8'h80);
        check(rd, 32'h00A00000);
        reverse_mode_pin = 1'b1;
        repeat (4) @(negedge core_clk);
        rd_reg(8'h80);
        check(rd, 32'h00200000);
        wr(32'h00000080, 32'hFFFFFFFF);
        rd_reg(8'h80);
        check(rd, 32'h0);
        // Lane 2 disabled: the clear must not reach the flag
        pulse_evt();
        cfg_master.set_byte_en(4'hB);
        wr(32'h00000080, 32'hFFFFFFFF);
        rd_reg(8'h80);
        check(rd, 32'h00200000);
        cfg_master.set_byte_en(4'hF);
        // Event and clear in the same cycle: the set has to win
        fork
            wr(32'h00000080, 32'hFFFFFFFF);
            pulse_evt();
        join
        rd_reg(8'h80);
        check(rd, 32'h00200000);
        wr(32'h00000080, 32'hFFFFFFFF);
        rd_reg(8'h80);
        check(rd, 32'h0);
        $display("split flag test done");
        // Mid-run reset brings every field back to its reset value
        reset = 1'b1;
        repeat (2) @(negedge core_clk);
        check({16'h0, completer_id}, 32'h0000FFF8);
        reset = 1'b0;
        repeat (3) @(negedge core_clk);
        rd_reg(8'h84);
        check(rd, 32'h00005AF8);
        rd_reg(8'h80);
        check(rd, 32'h0);
        $display("mid-run reset test done");
        pri_pcix_mode = 1'b1;
        #1;
        check({31'h0, mixed_mode_id_use}, 32'h1);
        sec_pcix_mode = 1'b1;
        #1;
        check({31'h0, mixed_mode_id_use}, 32'h0);
        $display("mixed mode test done");
        test_done();
    end
endmodule
